// ### dac_port_pkg.sv
// constants for the serial converter command port
package dac_port_pkg;
  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CMD_BITS = 4;
  localparam logic [3:0] CMD_SET_UPDATE = 4'h0;
  localparam logic [3:0] CMD_POWER = 4'hF;
  localparam logic [1:0] PWR_WAKE = 2'h0;
  localparam logic [1:0] PWR_FLOAT = 2'h1;
  localparam logic [1:0] PWR_1K = 2'h2;
  localparam logic [1:0] PWR_100K = 2'h3;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [1:0] TERM_RESET = PWR_100K;
  localparam logic [4:0] BIT_COUNT_FULL = 5'h10;
  localparam int WAKE_RECOVERY_NS = 8000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int WAKE_RECOVERY_CYCLES = (WAKE_RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// ### serial_dac_command_port.sv
// serial command port and power control of a 12-bit voltage converter
`timescale 1ns/1ps
module serial_dac_command_port
  import dac_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic frame_sel_n,
  input wire logic shift_clk,
  input wire logic serial_data,
  output logic [11:0] code_field,
  output logic powered_down,
  output logic [1:0] term_mode,
  output logic word_done,
  output logic wake_settling
);

  // ==========================================
  // input synchronisers
  logic [2:0] sel_sync_reg;
  logic [2:0] clk_sync_reg;
  logic [1:0] dat_sync_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      sel_sync_reg <= 3'h7;
      clk_sync_reg <= 3'h0;
      dat_sync_reg <= 2'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[1:0], frame_sel_n};
      clk_sync_reg <= {clk_sync_reg[1:0], shift_clk};
      dat_sync_reg <= {dat_sync_reg[0], serial_data};
    end
  end

  // edge detectors compare the second stage with the third; data uses the second
  logic sel_n;
  logic sel_fall;
  logic sel_rise;
  logic sclk_fall;
  assign sel_n = sel_sync_reg[1];
  assign sel_fall = sel_sync_reg[2] & ~sel_sync_reg[1];
  assign sel_rise = ~sel_sync_reg[2] & sel_sync_reg[1];
  // edge only
  // detection by transition works from either idle level
  assign sclk_fall = clk_sync_reg[2] & ~clk_sync_reg[1];

  // ==========================================
  // shifter
  logic [15:0] shift_reg;
  logic [4:0] count_reg;
  logic armed_reg;
  logic exec;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
      armed_reg <= 1'b0;
    end else if (sel_fall) begin
      count_reg <= 5'h00;
      armed_reg <= 1'b1;
    end else if (sel_rise || sel_n) begin
      // partial word dropped; count only matters while armed
      armed_reg <= 1'b0;
    end else if (armed_reg && sclk_fall) begin
      shift_reg <= {shift_reg[14:0], dat_sync_reg[1]};
      count_reg <= count_reg + 5'h01;
      if (count_reg == BIT_COUNT_FULL - 5'h01) begin
        armed_reg <= 1'b0;
      end
    end
  end

  assign exec = armed_reg && !sel_n && !sel_fall && sclk_fall
    && (count_reg == BIT_COUNT_FULL - 5'h01);

  logic [15:0] word;
  assign word = {shift_reg[14:0], dat_sync_reg[1]};

  // ==========================================
  // command decoding
  // the word is only meaningful in the cycle that exec is high
  function automatic logic is_set_cmd(input logic [15:0] w);
    return w[15:12] == CMD_SET_UPDATE;
  endfunction

  function automatic logic is_power_cmd(input logic [15:0] w);
    return w[15:12] == CMD_POWER;
  endfunction

  function automatic logic is_wake_cmd(input logic [15:0] w);
    return is_power_cmd(w) && (w[1:0] == PWR_WAKE);
  endfunction

  // ==========================================
  // elaboration checks
  // the shifter assumes a 4-bit command above a 12-bit code
  if (WORD_BITS != CMD_BITS + CODE_BITS || CODE_BITS != 12) begin : g_bad_word
    $error("word layout does not match the shifter");
  end
  // the recovery counter is 11 bits wide
  if (WAKE_RECOVERY_CYCLES < 1 || WAKE_RECOVERY_CYCLES > 2047) begin : g_bad_wake
    $error("recovery count does not fit the counter");
  end

  // ==========================================
  // converter state
  logic [10:0] wake_cnt_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      code_field <= CODE_RESET;
      powered_down <= 1'b1;
      term_mode <= TERM_RESET;
      word_done <= 1'b0;
    end else begin
      word_done <= exec;
      if (exec) begin
        if (is_set_cmd(word)) begin
          code_field <= word[11:0];
        end else if (is_power_cmd(word)) begin
          if (word[1:0] == PWR_WAKE) begin
            powered_down <= 1'b0;
          end else begin
            powered_down <= 1'b1;
            term_mode <= word[1:0];
          end
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wake_cnt_reg <= 11'h000;
    end else if (exec && is_wake_cmd(word)) begin
      wake_cnt_reg <= 11'(WAKE_RECOVERY_CYCLES);
    end else if (wake_cnt_reg != 11'h000) begin
      wake_cnt_reg <= wake_cnt_reg - 11'h001;
    end
  end
  assign wake_settling = (wake_cnt_reg != 11'h000);

  // ==========================================
  // checks
  a_code_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && is_set_cmd(word) |=> code_field == $past(word[11:0]))
    else $error("code not loaded");
  a_done_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    word_done |=> !word_done)
    else $error("word done held too long");
  a_ignore_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && !is_set_cmd(word) && !is_power_cmd(word)
    |=> $stable(code_field) && $stable(powered_down) && $stable(term_mode))
    else $error("bad command changed state");
  a_keep_code: assert property (@(posedge sys_clk) disable iff (!resetn)
    !exec |=> $stable(code_field))
    else $error("code changed without word");
  a_wake_keep: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && is_wake_cmd(word) |=> $stable(code_field) && $stable(term_mode))
    else $error("wake changed code or termination");
  a_wake_cmd: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && is_wake_cmd(word) |=> !powered_down)
    else $error("wake failed");
  a_pd_mode: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && is_power_cmd(word) && !is_wake_cmd(word)
    |=> powered_down && term_mode == $past(word[1:0]))
    else $error("power-down mode wrong");
  a_drop_part: assert property (@(posedge sys_clk) disable iff (!resetn)
    sel_rise && armed_reg
    |=> !armed_reg && $stable(code_field) && $stable(powered_down) && $stable(term_mode))
    else $error("partial word not discarded");
  a_one_word: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec |=> !armed_reg)
    else $error("shifter still armed after word");
  a_count_range: assert property (@(posedge sys_clk) disable iff (!resetn)
    count_reg <= BIT_COUNT_FULL)
    else $error("bit count ran past a word");
  a_reset_state: assert property (@(posedge sys_clk)
    !resetn |=> code_field == CODE_RESET && powered_down && term_mode == TERM_RESET)
    else $error("reset state wrong");
  a_wake_load: assert property (@(posedge sys_clk) disable iff (!resetn)
    exec && is_wake_cmd(word) |=> wake_cnt_reg == 11'(WAKE_RECOVERY_CYCLES))
    else $error("recovery count not loaded");
  a_wake_wait: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(wake_settling) |-> wake_settling [*8])
    else $error("recovery too short");
  a_settle_end: assert property (@(posedge sys_clk) disable iff (!resetn)
    wake_cnt_reg == 11'h001 && !(exec && is_wake_cmd(word)) |=> !wake_settling)
    else $error("recovery did not end");
  a_frame_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    sel_fall |=> armed_reg && count_reg == 5'h00)
    else $error("frame start missed");
  a_bit_count: assert property (@(posedge sys_clk) disable iff (!resetn)
    armed_reg && !sel_n && !sel_fall && sclk_fall
    |=> count_reg == $past(count_reg) + 5'h01)
    else $error("bit not counted");
  a_shift_in: assert property (@(posedge sys_clk) disable iff (!resetn)
    armed_reg && !sel_n && !sel_fall && sclk_fall
    |=> shift_reg[0] == $past(dat_sync_reg[1]))
    else $error("bit not shifted in");
endmodule

// ### host_master.sv
// host serial master model driving the converter command pins
`timescale 1ns/1ps
module host_master (
  input wire logic sys_clk,
  output logic frame_sel_n,
  output logic shift_clk,
  output logic serial_data
);
  // half of the 160 ns link clock period, in bench clock cycles
  localparam int HALF_CYCLES = 8;
  initial begin
    frame_sel_n = 1'b1;
    shift_clk = 1'b0;
    serial_data = 1'b0;
  end
  // msb first, set a half period before each fall
  task automatic send(input logic [15:0] w, input int n, input logic idle);
    shift_clk <= idle;
    repeat (HALF_CYCLES) @(posedge sys_clk);
    frame_sel_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      shift_clk <= 1'b1;
      serial_data <= (i < 16) ? w[15-i] : ~serial_data;
      repeat (HALF_CYCLES) @(posedge sys_clk);
      shift_clk <= 1'b0;
      repeat (HALF_CYCLES) @(posedge sys_clk);
    end
    shift_clk <= idle;
    repeat (4) @(posedge sys_clk);
    // select high well over 80 ns between frames
    frame_sel_n <= 1'b1;
    serial_data <= ~serial_data;
    repeat (20) @(posedge sys_clk);
  endtask
endmodule

// ### tb.sv
// self-checking bench for the serial converter command port
`timescale 1ns/1ps
module tb;
  import dac_port_pkg::*;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic frame_sel_n, shift_clk, serial_data, powered_down, word_done, wake_settling;
  logic [11:0] code_field;
  logic [1:0] term_mode;
  int failures = 0;
  int check_count = 0;
  int pulses = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (word_done === 1'b1) pulses++;
  host_master host (.sys_clk(sys_clk), .frame_sel_n(frame_sel_n), .shift_clk(shift_clk),
    .serial_data(serial_data));
  serial_dac_command_port dut (.sys_clk(sys_clk), .resetn(resetn),
    .frame_sel_n(frame_sel_n), .shift_clk(shift_clk), .serial_data(serial_data),
    .code_field(code_field), .powered_down(powered_down), .term_mode(term_mode),
    .word_done(word_done), .wake_settling(wake_settling));
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_state(input logic [11:0] c, input logic pd, input logic [1:0] t);
    check_val({1'b0, code_field, powered_down, term_mode}, {1'b0, c, pd, t});
  endtask
  task automatic end_of_test();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check_state(12'h000, 1'b1, 2'h3);
    host.send(16'hF000, 16, 1'b0);
    check_state(12'h000, 1'b0, 2'h3);
    check_val({15'h0, wake_settling}, 16'h0001);
    repeat (WAKE_RECOVERY_CYCLES - 40) @(posedge sys_clk);
    check_val({15'h0, wake_settling}, 16'h0001);
    repeat (40) @(posedge sys_clk);
    check_val({15'h0, wake_settling}, 16'h0000);
    host.send(16'h0ABC, 16, 1'b1);
    check_state(12'hABC, 1'b0, 2'h3);
    for (int m = 1; m < 4; m++) begin
      host.send({14'h3C00, m[1:0]}, 16, 1'b0);
      check_state(12'hABC, 1'b1, m[1:0]);
    end
    host.send(16'hF000, 16, 1'b1);
    check_state(12'hABC, 1'b0, 2'h3);
    repeat (WAKE_RECOVERY_CYCLES) @(posedge sys_clk);
    host.send(16'h0123, 15, 1'b0);
    check_state(12'hABC, 1'b0, 2'h3);
    host.send(16'h5123, 16, 1'b0);
    check_state(12'hABC, 1'b0, 2'h3);
    host.send(16'h0456, 20, 1'b0);
    check_state(12'h456, 1'b0, 2'h3);
    check_val(pulses[15:0], 16'h0008);
    host.send(16'hF002, 16, 1'b0);
    check_state(12'h456, 1'b1, 2'h2);
    // mid-run reset must bring back the power-on state
    resetn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    check_state(12'h000, 1'b1, 2'h3);
    end_of_test();
  end
endmodule
